/* File: design/ipr_pkg.sv */
// constants and types for the load/store control register group
// ****************************************************************
// Behaviour
// - chip reset clears the mode register; timeout reset clears only arbiter block
// - load_merge_off forces new load entries that never merge afterwards
// - write_buffer_force_drain drains the write buffer while any entry is valid
// - store_merge_off forces new store entries that never merge afterwards
// - io_load_merge_off stops loads with address bit 39 set from merging
// - drain_timer_off: oldest store waits for load_locked or a second entry
// - arbiter_block masks load and store requests; retry, replay, fetch, barrier pass
// - mode bit 6 reads one while any load miss is outstanding
// - mode bit 7 reads one while any store is outstanding
// - any write to the invalidate register clears valid bits in both banks
// - write-only register holds the alternate privilege mode for privileged loads/stores
// - enabled counter low half increments each cycle; upper half is an offset
// - writing the cycle counter changes bits 63..32 only
// - reading the cycle counter returns all 64 bits
// - counting starts three cycles after an enabling control write
// - chip reset leaves the counter disabled
// - control write loads bits 31..4, zeroes bits 3..0, keeps upper half
// - control bit 32 enables counting when one, disables when zero
// ****************************************************************
package ipr_pkg;
   // register selects on the privileged write/read ports
   typedef enum logic [2:0] {
      SEL_MODE = 3'h0,
      SEL_INVALIDATE = 3'h1,
      SEL_ALT_PRIV = 3'h2,
      SEL_COUNTER = 3'h3,
      SEL_COUNTER_CTL = 3'h4
   } reg_sel_type;

   typedef enum logic [1:0] {
      PRIV_KERNEL = 2'h0,
      PRIV_EXECUTIVE = 2'h1,
      PRIV_SUPERVISOR = 2'h2,
      PRIV_USER = 2'h3
   } priv_mode_type;

   // mode register fields
   localparam int MODE_LOAD_NOMERGE = 0;
   localparam int MODE_FORCE_DRAIN = 1;
   localparam int MODE_STORE_NOMERGE = 2;
   localparam int MODE_IO_NOMERGE = 3;
   localparam int MODE_TIMER_OFF = 4;
   localparam int MODE_ARB_BLOCK = 5;
   localparam int MODE_LOAD_PEND = 6;
   localparam int MODE_STORE_PEND = 7;
   localparam int MODE_CTRL_W = 6;
   localparam logic [5:0] MODE_RST = 6'h00;
   localparam logic [1:0] ALT_RST = 2'h0;

   // cycle counter fields
   localparam int DATA_W = 64;
   localparam int HALF_W = 32;
   localparam int CTL_ENA_BIT = 32;
   localparam int CTL_CNT_LSB = 4;
   localparam logic [63:0] CNT_RST = 64'h0000_0000_0000_0000;
   localparam int ENA_DELAY = 3;

   // miss queue and write buffer
   localparam int ADDR_W = 40;
   localparam int IO_ADDR_BIT = 39;
   localparam int LINE_LSB = 5;
   localparam int LINE_W = ADDR_W - LINE_LSB;
   localparam int QUEUE_DEPTH = 4;
   localparam int IDX_W = 2;
   localparam int CNT_W = 3;
   localparam int DRAIN_CYCLES = 64;
   localparam int TIMER_W = 6;
   localparam logic [5:0] TIMER_LAST = 6'(DRAIN_CYCLES - 1);
endpackage

/* File: design/merge_file.sv */
// tracking file for outstanding misses with merge and per-entry merge lock
`timescale 1ns/1ns
`default_nettype none
module merge_file (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic issue_valid,
   input wire logic [ipr_pkg::LINE_W-1:0] issue_line,
   input wire logic no_merge,
   output logic issue_ready,
   input wire logic retire_valid,
   input wire logic [ipr_pkg::IDX_W-1:0] retire_idx,
   output logic any_valid,
   output logic [ipr_pkg::CNT_W-1:0] entry_count
);
   localparam int DEPTH = ipr_pkg::QUEUE_DEPTH;

   logic [DEPTH-1:0] valid_r;
   logic [DEPTH-1:0] valid_nxt;
   logic [DEPTH-1:0] lock_r;
   logic [ipr_pkg::LINE_W-1:0] line_r [DEPTH];
   logic [DEPTH-1:0] hit;
   logic [ipr_pkg::IDX_W-1:0] free_idx;
   logic free_ok;
   logic merge;
   logic alloc;

   // ****************************************
   // match and free slot search
   // ****************************************
   // locked entries never match, so a merge can never land in them
   always_comb begin
      hit = '0;
      free_idx = '0;
      free_ok = 1'b0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (!valid_r[i]) begin
            free_ok = 1'b1;
            free_idx = i[ipr_pkg::IDX_W-1:0];
         end
         hit[i] = valid_r[i] && !lock_r[i] && (line_r[i] == issue_line);
      end
   end

   // merge decision and allocation
   assign merge = issue_valid && !no_merge && (|hit);
   assign alloc = issue_valid && !merge && free_ok;
   assign issue_ready = merge || free_ok; // a full file stalls the issuer unless the issue merges
   assign any_valid = |valid_r;
   assign entry_count = ipr_pkg::CNT_W'($countones(valid_r));

   always_comb begin
      valid_nxt = valid_r;
      if (retire_valid) begin
         valid_nxt[retire_idx] = 1'b0;
      end
      if (alloc) begin
         valid_nxt[free_idx] = 1'b1;
      end
   end

   // entry state
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         valid_r <= '0;
         lock_r <= '0;
      end else if (ce && alloc) begin
         valid_r <= valid_nxt;
         lock_r[free_idx] <= no_merge;
      end else if (ce) begin
         valid_r <= valid_nxt;
      end
   end

   // line addresses need no reset: only valid entries are compared
   always_ff @(posedge mclk) begin
      if (ce && alloc) begin
         line_r[free_idx] <= issue_line;
      end
   end

   a_nomerge_alloc: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && issue_valid && no_merge && free_ok) |=> (entry_count == $past(entry_count)
      + ipr_pkg::CNT_W'(1) - ipr_pkg::CNT_W'($past(retire_valid && valid_r[retire_idx]))))
      else $error("no-merge issue did not take a new entry");
endmodule
`default_nettype wire

/* File: design/lsu_ipr_bank.sv */
// load/store unit control registers, miss arbiter gating and cycle counter
`timescale 1ns/1ns
`default_nettype none
module lsu_ipr_bank (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic timeout_rst,
   input wire logic reg_wr_en,
   input wire logic [2:0] reg_wr_sel,
   input wire logic [63:0] reg_wr_data,
   input wire logic reg_rd_en,
   input wire logic [2:0] reg_rd_sel,
   output logic [63:0] reg_rd_data,
   output logic reg_rd_valid,
   input wire logic ld_issue_valid,
   input wire logic [39:0] ld_issue_addr,
   output logic ld_issue_ready,
   input wire logic ld_retire_valid,
   input wire logic [1:0] ld_retire_idx,
   input wire logic st_issue_valid,
   input wire logic [39:0] st_issue_addr,
   output logic st_issue_ready,
   input wire logic st_retire_valid,
   input wire logic [1:0] st_retire_idx,
   input wire logic load_locked_issue,
   input wire logic retry_req,
   input wire logic replay_req,
   input wire logic barrier_req,
   input wire logic ifetch_req,
   output logic retry_grant,
   output logic replay_grant,
   output logic barrier_grant,
   output logic ifetch_grant,
   output logic ld_grant,
   output logic st_grant,
   output logic write_buffer_force_drain,
   output logic dc_inval_bank0,
   output logic dc_inval_bank1,
   output logic [1:0] alternate_privilege
);

   logic [ipr_pkg::MODE_CTRL_W-1:0] mode_r;
   logic [ipr_pkg::MODE_CTRL_W-1:0] mode_nxt;
   logic [1:0] alt_r;
   logic inval_r;
   logic [63:0] cnt_r;
   logic [63:0] cnt_nxt;
   logic [ipr_pkg::ENA_DELAY-1:0] run_r;
   logic [ipr_pkg::TIMER_W-1:0] timer_r;
   logic ll_seen_r;
   logic [63:0] rd_data_r;
   logic rd_valid_r;

   // ****************************************
   // write decode
   // ****************************************
   // write-only registers read back as zero; no bus error exists on this port
   wire wr_mode = reg_wr_en && (reg_wr_sel == ipr_pkg::SEL_MODE);
   wire wr_inval = reg_wr_en && (reg_wr_sel == ipr_pkg::SEL_INVALIDATE);
   wire wr_alt = reg_wr_en && (reg_wr_sel == ipr_pkg::SEL_ALT_PRIV);
   wire wr_cnt = reg_wr_en && (reg_wr_sel == ipr_pkg::SEL_COUNTER);
   wire wr_ctl = reg_wr_en && (reg_wr_sel == ipr_pkg::SEL_COUNTER_CTL);

   // mode bit aliases
   wire load_merge_off = mode_r[ipr_pkg::MODE_LOAD_NOMERGE];
   wire drain_force = mode_r[ipr_pkg::MODE_FORCE_DRAIN];
   wire store_merge_off = mode_r[ipr_pkg::MODE_STORE_NOMERGE];
   wire io_load_merge_off = mode_r[ipr_pkg::MODE_IO_NOMERGE];
   wire drain_timer_off = mode_r[ipr_pkg::MODE_TIMER_OFF];
   wire arbiter_block = mode_r[ipr_pkg::MODE_ARB_BLOCK];

   // ****************************************
   // miss queue and write buffer
   // ****************************************
   wire ld_io = ld_issue_addr[ipr_pkg::IO_ADDR_BIT];
   wire ld_nomerge = load_merge_off || (io_load_merge_off && ld_io);
   wire ld_any;
   wire st_any;
   wire [ipr_pkg::CNT_W-1:0] ld_cnt;
   wire [ipr_pkg::CNT_W-1:0] st_cnt;

   merge_file u_miss_queue (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .issue_valid(ld_issue_valid),
      .issue_line(ld_issue_addr[ipr_pkg::ADDR_W-1:ipr_pkg::LINE_LSB]),
      .no_merge(ld_nomerge),
      .issue_ready(ld_issue_ready),
      .retire_valid(ld_retire_valid),
      .retire_idx(ld_retire_idx),
      .any_valid(ld_any),
      .entry_count(ld_cnt)
   );

   merge_file u_write_buffer (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .issue_valid(st_issue_valid),
      .issue_line(st_issue_addr[ipr_pkg::ADDR_W-1:ipr_pkg::LINE_LSB]),
      .no_merge(store_merge_off),
      .issue_ready(st_issue_ready),
      .retire_valid(st_retire_valid),
      .retire_idx(st_retire_idx),
      .any_valid(st_any),
      .entry_count(st_cnt)
   );

   // ****************************************
   // arbiter
   // ****************************************
   // the oldest store normally waits out the drain timer before asking
   wire timer_hit = (timer_r == ipr_pkg::TIMER_LAST);
   wire st_second = (st_cnt >= ipr_pkg::CNT_W'(2));
   wire st_low = drain_timer_off ? (ll_seen_r || st_second) : timer_hit;
   assign write_buffer_force_drain = drain_force && st_any;
   wire st_req = st_any && (write_buffer_force_drain || st_low);
   wire ld_req = ld_any;

   // fixed priority; loads and stores masked while blocked
   wire ld_ok = ld_req && !arbiter_block;
   wire st_ok = st_req && !arbiter_block;
   assign retry_grant = retry_req;
   assign replay_grant = replay_req && !retry_req;
   assign barrier_grant = barrier_req && !retry_req && !replay_req;
   wire hi_busy = retry_req || replay_req || barrier_req;
   assign ifetch_grant = ifetch_req && !hi_busy;
   assign ld_grant = ld_ok && !hi_busy && !ifetch_req;
   assign st_grant = st_ok && !hi_busy && !ifetch_req && !ld_ok;

   // drain timer restarts whenever a store wins or the buffer empties
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         timer_r <= '0;
      end else if (ce && (st_grant || !st_any || drain_timer_off)) begin
         timer_r <= '0;
      end else if (ce && !timer_hit) begin
         timer_r <= timer_r + ipr_pkg::TIMER_W'(1);
      end
   end

   // a load_locked in the same cycle as a grant still counts
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ll_seen_r <= 1'b0;
      end else if (ce) begin
         ll_seen_r <= load_locked_issue || (ll_seen_r && !st_grant && st_any);
      end
   end

   // ****************************************
   // mode, invalidate and alternate privilege
   // ****************************************
   // timeout reset beats a same-cycle write so the arbiter is always freed
   always_comb begin
      mode_nxt = wr_mode ? reg_wr_data[ipr_pkg::MODE_CTRL_W-1:0] : mode_r;
      if (timeout_rst) begin
         mode_nxt[ipr_pkg::MODE_ARB_BLOCK] = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         mode_r <= ipr_pkg::MODE_RST;
         alt_r <= ipr_pkg::ALT_RST;
         inval_r <= 1'b0;
      end else if (ce) begin
         mode_r <= mode_nxt;
         alt_r <= wr_alt ? reg_wr_data[1:0] : alt_r;
         inval_r <= wr_inval;
      end
   end

   // one-cycle clear of every valid bit, data value ignored
   assign dc_inval_bank0 = inval_r;
   assign dc_inval_bank1 = inval_r;
   assign alternate_privilege = alt_r;

   // ****************************************
   // cycle counter
   // ****************************************
   // enable travels down a three-stage pipe, so disable lags equally
   wire cnt_inc = run_r[ipr_pkg::ENA_DELAY-1];
   wire [31:0] lo_inc = cnt_r[31:0] + 32'h1;
   wire [31:0] ctl_lo = {reg_wr_data[31:ipr_pkg::CTL_CNT_LSB], 4'h0};

   // a control write wins over a same-cycle increment of the low half
   always_comb begin
      cnt_nxt = cnt_r;
      if (cnt_inc) begin
         cnt_nxt[31:0] = lo_inc;
      end
      if (wr_ctl) begin
         cnt_nxt[31:0] = ctl_lo;
      end
      if (wr_cnt) begin
         cnt_nxt[63:32] = reg_wr_data[63:32];
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cnt_r <= ipr_pkg::CNT_RST;
         run_r <= '0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         run_r[0] <= wr_ctl ? reg_wr_data[ipr_pkg::CTL_ENA_BIT] : run_r[0];
         run_r[ipr_pkg::ENA_DELAY-1:1] <= run_r[ipr_pkg::ENA_DELAY-2:0];
      end
   end

   // ****************************************
   // read port
   // ****************************************
   wire [7:0] mode_view = {st_any, ld_any, mode_r};
   wire rd_mode = (reg_rd_sel == ipr_pkg::SEL_MODE);
   wire rd_cnt = (reg_rd_sel == ipr_pkg::SEL_COUNTER);
   wire [63:0] rd_mux = rd_cnt ? cnt_r : (rd_mode ? {56'h0, mode_view} : 64'h0);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rd_data_r <= '0;
         rd_valid_r <= 1'b0;
      end else if (ce) begin
         rd_data_r <= reg_rd_en ? rd_mux : rd_data_r;
         rd_valid_r <= reg_rd_en;
      end
   end

   assign reg_rd_data = rd_data_r;
   assign reg_rd_valid = rd_valid_r;

   // ****************************************
   // checks
   // ****************************************
   a_mode_reset: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(nrst) |-> (mode_r == ipr_pkg::MODE_RST) && !run_r[0])
      else $error("mode register not cleared by reset");

   a_timeout_clear: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && timeout_rst) |=> !arbiter_block
      && (mode_r[4:0] == $past(mode_nxt[4:0])))
      else $error("timeout reset handled arbiter block wrongly");

   a_drain_force: assert property (@(posedge mclk) disable iff (!nrst)
      (drain_force && st_any && !arbiter_block && !hi_busy && !ifetch_req && !ld_ok)
      |-> st_grant)
      else $error("forced drain did not request the write buffer");

   a_arb_block: assert property (@(posedge mclk) disable iff (!nrst)
      arbiter_block |-> !ld_grant && !st_grant && (retry_grant == retry_req))
      else $error("blocked arbiter granted a load or store");

   a_timer_low: assert property (@(posedge mclk) disable iff (!nrst)
      (drain_timer_off && st_any && !st_second && !ll_seen_r && !drain_force)
      |-> !st_grant)
      else $error("store arbitrated without trigger while timer off");

   a_pend_flags: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && reg_rd_en && rd_mode) |=> reg_rd_valid
      && (reg_rd_data[7:6] == {$past(st_any), $past(ld_any)}))
      else $error("pending flags misreported");

   a_inval_pulse: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && wr_inval) |=> dc_inval_bank0 && dc_inval_bank1)
      else $error("invalidate write gave no pulse");

   a_cnt_start: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && wr_ctl && reg_wr_data[32] && !run_r[2] && !run_r[1])
      ##1 (ce && !reg_wr_en)[*4] |-> cnt_r[31:0] == $past(cnt_r[31:0], 3) + 32'h1)
      else $error("counter did not start three cycles after enable");

   a_ctl_load: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && wr_ctl) |=> (cnt_r[31:0] == {$past(reg_wr_data[31:4]), 4'h0})
      && (cnt_r[63:32] == $past(cnt_r[63:32])))
      else $error("control write loaded counter wrongly");

   a_offset_write: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && wr_cnt && !cnt_inc) |=> (cnt_r[31:0] == $past(cnt_r[31:0]))
      && (cnt_r[63:32] == $past(reg_wr_data[63:32])))
      else $error("counter write touched the low half");

   a_lo_wrap: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && cnt_inc && !reg_wr_en && (cnt_r[31:0] == 32'hFFFF_FFFF))
      |=> (cnt_r[31:0] == 32'h0) && $stable(cnt_r[63:32]))
      else $error("low half wrap disturbed the offset");

   a_cnt_step: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && cnt_inc && !reg_wr_en) |=> (cnt_r[31:0] == $past(cnt_r[31:0]) + 32'h1)
      && $stable(cnt_r[63:32]))
      else $error("enabled counter did not step by one");

   a_cnt_read: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && reg_rd_en && rd_cnt) |=> reg_rd_valid && (reg_rd_data == $past(cnt_r)))
      else $error("counter read lost bits");

   a_alt_write: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && wr_alt) |=> (alternate_privilege == $past(reg_wr_data[1:0])))
      else $error("alternate privilege write not held");
endmodule
`default_nettype wire

/* File: sim/miss_file_mode_and_cycle_counter_test.sv */
// self-checking bench for the load/store control register group
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
module miss_file_mode_and_cycle_counter_test;
   typedef struct {logic [2:0] sel; logic [63:0] d; logic [63:0] exp;} reg_row_type;
   typedef struct {bit st; logic [5:0] m; logic [39:0] a; logic exp;} merge_row_type;
   typedef struct {logic [31:0] init; int k;} cnt_row_type;
   // ****************************************************************
   // clock, stimulus signals and the unit
   // ****************************************************************
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic timeout_rst = 1'b0;
   logic reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic [2:0] reg_wr_sel = 3'h0, reg_rd_sel = 3'h0;
   logic [63:0] reg_wr_data = 64'h0, reg_rd_data, d, d2;
   logic reg_rd_valid, ld_issue_ready, st_issue_ready;
   logic ld_issue_valid = 1'b0, st_issue_valid = 1'b0;
   logic [39:0] ld_issue_addr = 40'h0, st_issue_addr = 40'h0;
   logic ld_retire_valid = 1'b0, st_retire_valid = 1'b0;
   logic [1:0] ld_retire_idx = 2'h0, st_retire_idx = 2'h0, alternate_privilege;
   logic load_locked_issue = 1'b0;
   logic retry_req = 1'b0, replay_req = 1'b0, barrier_req = 1'b0, ifetch_req = 1'b0;
   logic retry_grant, replay_grant, barrier_grant, ifetch_grant, ld_grant, st_grant;
   logic write_buffer_force_drain, dc_inval_bank0, dc_inval_bank1;
   int bad_count = 0;
   int cmp_count = 0;
   int n0, n1;
   always #4 mclk = ~mclk;
   lsu_ipr_bank DUT (.mclk(mclk), .nrst(nrst), .ce(ce), .timeout_rst(timeout_rst),
      .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data),
      .reg_rd_en(reg_rd_en), .reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid), .ld_issue_valid(ld_issue_valid),
      .ld_issue_addr(ld_issue_addr), .ld_issue_ready(ld_issue_ready),
      .ld_retire_valid(ld_retire_valid), .ld_retire_idx(ld_retire_idx),
      .st_issue_valid(st_issue_valid), .st_issue_addr(st_issue_addr),
      .st_issue_ready(st_issue_ready), .st_retire_valid(st_retire_valid),
      .st_retire_idx(st_retire_idx), .load_locked_issue(load_locked_issue),
      .retry_req(retry_req), .replay_req(replay_req), .barrier_req(barrier_req),
      .ifetch_req(ifetch_req), .retry_grant(retry_grant), .replay_grant(replay_grant),
      .barrier_grant(barrier_grant), .ifetch_grant(ifetch_grant), .ld_grant(ld_grant),
      .st_grant(st_grant), .write_buffer_force_drain(write_buffer_force_drain),
      .dc_inval_bank0(dc_inval_bank0), .dc_inval_bank1(dc_inval_bank1),
      .alternate_privilege(alternate_privilege));
   // ****************************************************************
   // bus tasks: each starts 1 ns after an edge and leaves an idle edge
   // ****************************************************************
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [2:0] sel, input logic [63:0] v);
      reg_wr_en = 1'b1;
      reg_wr_sel = sel;
      reg_wr_data = v;
      step(1);
      reg_wr_en = 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [2:0] sel, output logic [63:0] v);
      reg_rd_en = 1'b1;
      reg_rd_sel = sel;
      step(1);
      reg_rd_en = 1'b0;
      `CHK(reg_rd_valid, 1'b1);
      v = reg_rd_data;
      step(1);
   endtask
   // full restart, so the miss and store files start empty
   task automatic restart;
      nrst = 1'b0;
      step(10);
      nrst = 1'b1;
      step(2);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      tally_and_finish();
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   reg_row_type regs [8] = '{
      '{3'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h3F}, '{3'h0, 64'h2A, 64'h2A},
      '{3'h7, 64'h15, 64'h2A}, '{3'h0, 64'h00, 64'h00},
      '{3'h2, 64'h0, 64'h0}, '{3'h2, 64'h1, 64'h1},
      '{3'h2, 64'h2, 64'h2}, '{3'h2, 64'hFFFF_FFFF_FFFF_FFF3, 64'h3}};
   merge_row_type merges [6] = '{
      '{1'b0, 6'h00, 40'h00_0000_1000, 1'b1}, '{1'b0, 6'h01, 40'h00_0000_1000, 1'b0},
      '{1'b0, 6'h08, 40'h80_0000_1000, 1'b0}, '{1'b0, 6'h08, 40'h00_0000_1000, 1'b1},
      '{1'b1, 6'h04, 40'h00_0000_2000, 1'b0}, '{1'b1, 6'h00, 40'h00_0000_2000, 1'b1}};
   cnt_row_type cnts [3] = '{'{32'h1234_5670, 1}, '{32'h1234_5670, 2}, '{32'hFFFF_FFF0, 19}};
   initial begin
      step(1);
      restart();
      // reset state: mode clear, counter zero and standing still
      rd(3'(ipr_pkg::SEL_MODE), d);
      `CHK(d, 64'h0);
      rd(3'(ipr_pkg::SEL_COUNTER), d);
      step(5);
      rd(3'(ipr_pkg::SEL_COUNTER), d2);
      `CHK(d2, 64'h0);
      $display("test reset values done");
      // mode and alternate privilege rows; select 7 must be ignored
      foreach (regs[i]) begin
         wr(regs[i].sel, regs[i].d);
         if (regs[i].sel == 3'h2) begin
            `CHK(alternate_privilege, regs[i].exp[1:0]);
         end else begin
            rd(3'(ipr_pkg::SEL_MODE), d);
            `CHK(d, regs[i].exp);
         end
      end
      $display("test register rows done");
      // merge lock: four issues to one line, then the mode is cleared
      foreach (merges[i]) begin
         restart();
         wr(3'(ipr_pkg::SEL_MODE), {58'h0, merges[i].m});
         ld_issue_addr = merges[i].a;
         st_issue_addr = merges[i].a;
         ld_issue_valid = !merges[i].st;
         st_issue_valid = merges[i].st;
         step(4);
         ld_issue_valid = 1'b0;
         st_issue_valid = 1'b0;
         wr(3'(ipr_pkg::SEL_MODE), 64'h0);
         ld_issue_valid = !merges[i].st;
         st_issue_valid = merges[i].st;
         step(1);
         `CHK(merges[i].st ? st_issue_ready : ld_issue_ready, merges[i].exp);
         ld_issue_valid = 1'b0;
         st_issue_valid = 1'b0;
         step(1);
         rd(3'(ipr_pkg::SEL_MODE), d);
         `CHK(d[7:6], merges[i].st ? 2'b10 : 2'b01);
         if (!merges[i].exp) begin
            ld_retire_valid = !merges[i].st;
            st_retire_valid = merges[i].st;
            for (int k = 0; k < 4; k++) begin
               ld_retire_idx = 2'(k);
               st_retire_idx = 2'(k);
               step(1);
            end
            ld_retire_valid = 1'b0;
            st_retire_valid = 1'b0;
            rd(3'(ipr_pkg::SEL_MODE), d);
            `CHK(d, 64'h0);
         end
      end
      $display("test merge rows done");
      // arbiter blocking, forced drain and timeout reset
      restart();
      ld_issue_valid = 1'b1;
      st_issue_valid = 1'b1;
      step(1);
      ld_issue_valid = 1'b0;
      st_issue_valid = 1'b0;
      `CHK({ld_grant, st_grant}, 2'b10);
      wr(3'(ipr_pkg::SEL_MODE), 64'h02);
      `CHK(write_buffer_force_drain, 1'b1);
      wr(3'(ipr_pkg::SEL_MODE), 64'h22);
      `CHK({ld_grant, st_grant}, 2'b00);
      for (int k = 0; k < 4; k++) begin
         {retry_req, replay_req, barrier_req, ifetch_req} = 4'h8 >> k;
         step(1);
         `CHK({retry_grant, replay_grant, barrier_grant, ifetch_grant}, 4'h8 >> k);
      end
      ifetch_req = 1'b0;
      step(1);
      timeout_rst = 1'b1;
      step(1);
      timeout_rst = 1'b0;
      rd(3'(ipr_pkg::SEL_MODE), d);
      `CHK(d, 64'hC2);
      `CHK(ld_grant, 1'b1);
      // with the load gone the forced drain lets the store win
      ld_retire_valid = 1'b1;
      ld_retire_idx = 2'h0;
      step(1);
      ld_retire_valid = 1'b0;
      `CHK(st_grant, 1'b1);
      // drain timer: the lone store waits out 64 cycles
      wr(3'(ipr_pkg::SEL_MODE), 64'h00);
      step(61);
      `CHK(st_grant, 1'b0);
      step(1);
      `CHK(st_grant, 1'b1);
      // timer off: only a load_locked releases the lone store
      wr(3'(ipr_pkg::SEL_MODE), 64'h10);
      `CHK(st_grant, 1'b0);
      load_locked_issue = 1'b1;
      step(1);
      load_locked_issue = 1'b0;
      `CHK(st_grant, 1'b1);
      $display("test arbiter done");
      // invalidate: exactly one pulse on each bank
      reg_wr_en = 1'b1;
      reg_wr_sel = 3'(ipr_pkg::SEL_INVALIDATE);
      reg_wr_data = 64'h5A5A_0000_0000_0001;
      step(1);
      reg_wr_en = 1'b0;
      n0 = 0;
      n1 = 0;
      for (int k = 0; k < 3; k++) begin
         n0 += int'(dc_inval_bank0 === 1'b1);
         n1 += int'(dc_inval_bank1 === 1'b1);
         step(1);
      end
      `CHK({n0[1:0], n1[1:0]}, 4'h5);
      $display("test invalidate done");
      // counter: offset write, enable latency, low nibble cleared, wrap
      wr(3'(ipr_pkg::SEL_COUNTER), 64'h0000_0007_FFFF_FFFF);
      rd(3'(ipr_pkg::SEL_COUNTER), d);
      `CHK(d, 64'h0000_0007_0000_0000);
      foreach (cnts[i]) begin
         wr(3'(ipr_pkg::SEL_COUNTER_CTL), 64'h0);
         step(6);
         wr(3'(ipr_pkg::SEL_COUNTER_CTL), {31'h0, 1'b1, cnts[i].init | 32'hF});
         step(cnts[i].k);
         rd(3'(ipr_pkg::SEL_COUNTER), d);
         `CHK(d, {32'h7, cnts[i].init + 32'(cnts[i].k - 1)});
      end
      // a low clock enable freezes the running count
      rd(3'(ipr_pkg::SEL_COUNTER), d);
      ce = 1'b0;
      step(5);
      ce = 1'b1;
      rd(3'(ipr_pkg::SEL_COUNTER), d2);
      `CHK(d2, d + 64'h2);
      // a disabling write stops the count once the pipe drains
      wr(3'(ipr_pkg::SEL_COUNTER_CTL), 64'h0);
      step(6);
      rd(3'(ipr_pkg::SEL_COUNTER), d);
      step(3);
      rd(3'(ipr_pkg::SEL_COUNTER), d2);
      `CHK(d2, d);
      $display("test cycle counter done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
